// ===== src/sdf_regs.svh
// Purpose: Constants of the sinc4 decimator.
// Assumes: 20 MHz system clock.
// Notes:   Divider counts are in system clock cycles; SDF_CONV_EXT_CYC is in external clock cycles.
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH
`define SDF_CLK_HZ        20000000
`define SDF_OSR           256
`define SDF_OUT_DIV       2048
`define SDF_FS_50_HZ      12800
`define SDF_FS_5060_HZ    13960
`define SDF_FS_60_HZ      15360
`define SDF_EXT_DIV       20
`define SDF_CONV_EXT_CYC  41036
`define SDF_EXT_NOM_HZ    307200
`define SDF_BW_PPM_X10    118
`define SDF_ACC_W         46
`define SDF_OUT_SHIFT     12
`define SDF_DIV_50        (`SDF_CLK_HZ / `SDF_FS_50_HZ)
`define SDF_DIV_5060      (`SDF_CLK_HZ / `SDF_FS_5060_HZ)
`define SDF_DIV_60        (`SDF_CLK_HZ / `SDF_FS_60_HZ)
`endif

// ===== src/sdf_pkg.sv
// Purpose: Types of the sinc4 decimator.
// Assumes: Nothing.
// Notes:   Rejection selection and accumulator width.
package sdf_pkg;
    typedef enum logic [1:0] {
        SDF_REJ_60, SDF_REJ_50, SDF_REJ_5060
    } sdf_rej_e;
    typedef logic [45:0] sdf_acc_t;
endpackage

// ===== src/sdf_decim.sv
// Purpose: Sinc4 decimator with calibration and 2x running average.
// Assumes: Modulator bit and external clock are synchronous inputs.
// Notes:   Offset calibration subtracts a zero-input conversion.
`timescale 1ns/1ns
`include "sdf_regs.svh"

// Contract
// - Sinc4 decimation plus offset calibration
// - Sample rate is 256 notch, 2048 output
// - Internal rates 12800, 13960, 15360 Hz
// - External clock divided by 20 samples
// - Bandwidth scales with external clock
// - Double speed skips offset calibration
// - Double speed averages previous and current
// - Double speed bandwidth follows rejection setting
// - Conversion lasts 41036 external clock cycles; a 1x block here takes 2048 x 20 = 40960
module sdf_decim
    import sdf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [1:0]        rej_sel,
    input  wire logic              ext_clk_sel,
    input  wire logic              ext_clk,
    input  wire logic              dbl_speed,
    input  wire logic              mod_bit,
    output logic                   mod_sample,
    output logic                   cal_phase,
    output logic                   res_valid,
    output logic signed [33:0]     res_data
);
    localparam int DIVW = 11;
    localparam int EXTW = 16;
    localparam logic [4:0] EXT_DIV = 5'(`SDF_EXT_DIV);
    localparam logic [10:0] DEC_N = 11'(`SDF_OUT_DIV - 1);
    localparam sdf_acc_t PLUS_ONE  = 46'h1;
    localparam sdf_acc_t MINUS_ONE = 46'h3FFFFFFFFFFF;
    localparam int OUT_SH = `SDF_OUT_SHIFT;

    ////////////////////////////////////////////////////////////////
    // Internal sample divider per rejection setting; code 3 runs as 60 Hz.
    function automatic logic [DIVW-1:0] div_of(input logic [1:0] s);
        unique case (s)
            2'(SDF_REJ_50):   div_of = DIVW'(`SDF_DIV_50);
            2'(SDF_REJ_5060): div_of = DIVW'(`SDF_DIV_5060);
            default:          div_of = DIVW'(`SDF_DIV_60);
        endcase
    endfunction

    logic [DIVW-1:0] div_r, div_nxt;
    logic [4:0]      ediv_r, ediv_nxt;
    logic            eclk_r, eclk_nxt;
    logic [EXTW-1:0] ecnt_r, ecnt_nxt;
    logic            tick;

    // Sample tick: internal divider per rejection, or external / 20.
    always_comb begin
        div_nxt  = div_r;
        ediv_nxt = ediv_r;
        eclk_nxt = ext_clk;
        ecnt_nxt = ecnt_r;
        tick     = 1'b0;
        if (ext_clk_sel) begin
            if (ext_clk && !eclk_r) begin
                ecnt_nxt = ecnt_r + 1'b1;
                if (ediv_r == EXT_DIV - 5'h01) begin
                    ediv_nxt = 5'h00;
                    tick     = 1'b1;
                end else begin
                    ediv_nxt = ediv_r + 5'h01;
                end
            end
        end else if (div_r >= div_of(rej_sel) - 1'b1) begin
            div_nxt = '0;
            tick    = 1'b1;
        end else begin
            div_nxt = div_r + 1'b1;
        end
    end

    // The edge detector rests low, matching the idle conversion clock.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_r  <= '0;
            ediv_r <= 5'h00;
            eclk_r <= 1'b0;
            ecnt_r <= '0;
        end else begin
            div_r  <= div_nxt;
            ediv_r <= ediv_nxt;
            eclk_r <= eclk_nxt;
            ecnt_r <= ecnt_nxt;
        end
    end

    assign mod_sample = tick;

    ////////////////////////////////////////////////////////////////
    // Four integrators on the sample tick, four combs on decimation.
    sdf_acc_t integ_r [4];
    sdf_acc_t integ_nxt [4];
    sdf_acc_t comb_r [4];
    sdf_acc_t comb_nxt [4];
    sdf_acc_t cdiff [5];
    logic [10:0] dcnt_r, dcnt_nxt;
    logic        dec;

    always_comb begin
        integ_nxt = integ_r;
        dcnt_nxt  = dcnt_r;
        dec       = 1'b0;
        if (tick) begin
            integ_nxt[0] = integ_r[0] + (mod_bit ? PLUS_ONE : MINUS_ONE);
            for (int i = 1; i < 4; i++) begin
                integ_nxt[i] = integ_r[i] + integ_nxt[i-1];
            end
            // Half-length blocks double the output rate in 2x mode.
            if (dcnt_r >= (dbl_speed ? DEC_N >> 1 : DEC_N)) begin
                dcnt_nxt = 11'h000;
                dec      = 1'b1;
            end else begin
                dcnt_nxt = dcnt_r + 11'h001;
            end
        end
    end

    // Comb stage g keeps the previous block's value of stage g.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_comb
            assign comb_nxt[g] = dec ? cdiff[g] : comb_r[g];
            assign cdiff[g+1]  = cdiff[g] - comb_r[g];
        end
    endgenerate
    assign cdiff[0] = integ_nxt[3];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            integ_r <= '{default: '0};
            comb_r  <= '{default: '0};
            dcnt_r  <= 11'h000;
        end else begin
            integ_r <= integ_nxt;
            comb_r  <= comb_nxt;
            dcnt_r  <= dcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Output: calibrated difference in 1x, running average in 2x.
    // Sums run at full accumulator width: a full-scale block of 2048
    // samples reaches 2048^4 = 2^44, which a 34-bit word would wrap.
    // The result is scaled down by OUT_SH bits to fit the output port.
    logic signed [45:0] raw, prev_r, prev_nxt, off_r, off_nxt, full;
    logic signed [33:0] data_nxt;
    logic               cal_r, cal_nxt, vld_nxt;
    logic [1:0]         fresh_r, fresh_nxt;
    logic [2:0]         cfg_r, cfg_nxt;

    assign raw = $signed(cdiff[4]);

    always_comb begin
        prev_nxt  = prev_r;
        off_nxt   = off_r;
        cal_nxt   = cal_r;
        fresh_nxt = fresh_r;
        data_nxt  = res_data;
        vld_nxt   = 1'b0;
        full      = '0;
        cfg_nxt   = {dbl_speed, rej_sel};
        // A speed or rejection change restarts the pairing, but the first average after it
        // still pairs with the block that straddles the change.
        if (cfg_r != cfg_nxt) begin
            fresh_nxt = 2'h0;
        end else if (dec) begin
            prev_nxt = raw;
            if (dbl_speed) begin
                if (fresh_r != 2'h2) begin
                    fresh_nxt = fresh_r + 2'h1;
                end
                if (fresh_r != 2'h0) begin
                    full     = (raw >>> 1) + (prev_r >>> 1);
                    data_nxt = 34'(full >>> OUT_SH);
                    vld_nxt  = 1'b1;
                end
            end else if (cal_r) begin
                off_nxt = raw;
                cal_nxt = 1'b0;
            end else begin
                full     = raw - off_r;
                data_nxt = 34'(full >>> OUT_SH);
                vld_nxt  = 1'b1;
                cal_nxt  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prev_r    <= '0;
            off_r     <= '0;
            cal_r     <= 1'b1;
            fresh_r   <= 2'h0;
            cfg_r     <= 3'h0;
            res_data  <= '0;
            res_valid <= 1'b0;
        end else begin
            prev_r    <= prev_nxt;
            off_r     <= off_nxt;
            cal_r     <= cal_nxt;
            fresh_r   <= fresh_nxt;
            cfg_r     <= cfg_nxt;
            res_data  <= data_nxt;
            res_valid <= vld_nxt;
        end
    end

    assign cal_phase = cal_r & ~dbl_speed;
endmodule

// ===== test/sdf_decim_chk.sv
// Purpose: Port assertions of the decimator.
// Assumes: Settings change only while in reset.
// Notes:   Gap counts clk cycles since a tick.
`timescale 1ns/1ns
module sdf_decim_chk (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic [1:0]         rej_sel,
    input wire logic               ext_clk_sel,
    input wire logic               dbl_speed,
    input wire logic               mod_sample,
    input wire logic               cal_phase,
    input wire logic               res_valid,
    input wire logic signed [33:0] res_data
);
    logic [10:0] gap_r;
    logic        seen_r;
    always_ff @(posedge clk) begin
        seen_r <= nrst && (seen_r || mod_sample);
        gap_r  <= (!nrst || mod_sample) ? 11'h000 : gap_r + 11'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence tick_s(logic [1:0] r);
        mod_sample && seen_r && !ext_clk_sel && rej_sel == r;
    endsequence
    gap_sixty_a: assert property (tick_s(2'h0)
        |-> gap_r == 11'h515) else $error("60 Hz tick gap");
    gap_fifty_a: assert property (tick_s(2'h1)
        |-> gap_r == 11'h619) else $error("50 Hz tick gap");
    gap_both_a: assert property (tick_s(2'h2)
        |-> gap_r == 11'h597) else $error("50/60 Hz tick gap");
    gap_ext_a: assert property (mod_sample && seen_r && ext_clk_sel
        |-> gap_r >= 11'h027) else $error("external tick gap");
    valid_pulse_a: assert property (res_valid |=> !res_valid)
        else $error("valid too long");
    data_hold_a: assert property ($changed(res_data) |-> res_valid)
        else $error("data moved without valid");
    reset_clear_a: assert property (disable iff (1'b0) !nrst
        |=> !res_valid && res_data == 34'h0) else $error("reset output");
    cal_first_a: assert property (disable iff (1'b0)
        !nrst && !dbl_speed |=> cal_phase) else $error("cal after reset");
endmodule

// ===== test/sdf_mod_model.sv
// Purpose: Modulator bit and conversion clock source.
// Assumes: Driven from the rising clk edge.
// Notes:   Conversion clock rests low when disabled.
`timescale 1ns/1ns
module sdf_mod_model (
    input  wire logic clk,
    input  wire logic ext_en,
    output logic      ext_clk = 1'b0,
    output logic      mod_bit
);
    assign mod_bit = 1'b1;
    always @(posedge clk) ext_clk <= ext_en ? ~ext_clk : 1'b0;
endmodule

// ===== test/sdf_decim_test.sv
// Purpose: Self-checking bench of the decimator.
// Assumes: 20 MHz clock, sync active-low reset.
// Notes:   The 2x run needs about 82000 cycles.
`timescale 1ns/1ns
module sdf_decim_test;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic [1:0]         rej_sel = 2'h0;
    logic               ext_clk_sel = 1'b0;
    logic               dbl_speed = 1'b0;
    logic               ext_clk;
    logic               mod_bit;
    logic               mod_sample;
    logic               cal_phase;
    logic               res_valid;
    logic signed [33:0] res_data;
    int                 error_cnt = 0;
    int                 cmp_count = 0;
    int                 n;
    initial forever #25 clk = ~clk;
    sdf_mod_model sdf_mod_model_i (.clk(clk), .ext_en(ext_clk_sel),
        .ext_clk(ext_clk), .mod_bit(mod_bit));
    sdf_decim sdf_decim_i (.clk(clk), .nrst(nrst), .rej_sel(rej_sel),
        .ext_clk_sel(ext_clk_sel), .ext_clk(ext_clk),
        .dbl_speed(dbl_speed), .mod_bit(mod_bit), .mod_sample(mod_sample),
        .cal_phase(cal_phase), .res_valid(res_valid), .res_data(res_data));
    task automatic check(input logic [33:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic [1:0] rej, input logic fast);
        @(posedge clk);
        nrst        <= 1'b0;
        rej_sel     <= rej;
        ext_clk_sel <= fast;
        dbl_speed   <= fast;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
    endtask
    // Leaves n as the cycle count up to the next tick.
    task automatic tick();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!mod_sample && n < 4000);
    endtask
    task automatic int_rates();
        logic [33:0] div [3] = '{34'h516, 34'h61A, 34'h598};
        for (int i = 0; i < 3; i++) begin
            do_reset(i[1:0], 1'b0);
            #1 check(cal_phase, 34'h1);
            tick();
            tick();
            check(n, div[i]);
        end
    endtask
    task automatic ext_double();
        int ticks;
        do_reset(2'h0, 1'b1);
        tick();
        tick();
        check(n, 34'h28);
        check(cal_phase, 34'h0);
        ticks = 2;
        n = 0;
        while (res_valid !== 1'b1 && n < 90000) begin
            @(posedge clk);
            #1 n++;
            if (mod_sample) ticks++;
        end
        check(ticks, 34'h800);
        check(res_data, 34'h0457D58F);
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        int_rates();
        ext_double();
        repeat (3) @(posedge clk);
        print_verdict();
    end
    initial begin
        #4_800_000;
        error_cnt++;
        print_verdict();
    end
endmodule
bind sdf_decim sdf_decim_chk sdf_decim_chk_i (.clk(clk), .nrst(nrst),
    .rej_sel(rej_sel), .ext_clk_sel(ext_clk_sel), .dbl_speed(dbl_speed),
    .mod_sample(mod_sample), .cal_phase(cal_phase),
    .res_valid(res_valid), .res_data(res_data));
